// file: hw/dud_pkg.sv
// constants, register map and carrier types of the differential decision block
package dud_pkg;

    // ==========================================================
    // widths
    localparam int MAG_W = 16;
    localparam int LVL_W = 12;
    localparam int PCT_W = 6;
    localparam int CMP_W = 24;

    // ==========================================================
    // register map (byte addresses)
    localparam logic [7:0] OFS_LEVEL = 8'h00;
    localparam logic [7:0] OFS_CHAR = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h0C;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h10;

    // ==========================================================
    // field positions
    localparam int CHAR_BASE_LSB = 0;
    localparam int CHAR_SLOPE_LSB = 8;
    localparam int STAT_RESTR_LSB = 0;
    localparam int STAT_UNRESTR_LSB = 3;
    localparam int STAT_RGEN_BIT = 6;
    localparam int STAT_UGEN_BIT = 7;
    localparam int STAT_DIS_BIT = 8;
    localparam int IRQ_RGEN_BIT = 0;
    localparam int IRQ_UGEN_BIT = 1;
    localparam int IRQ_W = 2;

    // ==========================================================
    // setting ranges and reset values, percent of reference current
    localparam logic [LVL_W-1:0] LEVEL_MIN = 12'h050;
    localparam logic [LVL_W-1:0] LEVEL_MAX = 12'h9C4;
    localparam logic [LVL_W-1:0] LEVEL_RST = 12'h320;
    localparam logic [PCT_W-1:0] PCT_MIN = 6'h0A;
    localparam logic [PCT_W-1:0] PCT_MAX = 6'h32;
    localparam logic [PCT_W-1:0] BASE_RST = 6'h14;
    localparam logic [PCT_W-1:0] SLOPE_RST = 6'h14;
    localparam logic [6:0] PCT_SCALE = 7'h64;
    localparam logic [IRQ_W-1:0] MASK_RST = 2'h0;

    // ==========================================================
    // ahb encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic [2:0][MAG_W-1:0] diff;
        logic [2:0][MAG_W-1:0] prim;
        logic [2:0][MAG_W-1:0] sec;
        logic [2:0][MAG_W-1:0] ter;
    } dud_mag_s;

    typedef struct packed {
        logic second_harm_restr_ph3;
        logic second_harm_restr_ph2;
        logic second_harm_restr_ph1;
        logic fifth_harm_restr_ph3;
        logic fifth_harm_restr_ph2;
        logic fifth_harm_restr_ph1;
    } dud_harm_s;

    typedef struct packed {
        logic unrestr_start_gen;
        logic restr_start_gen;
        logic unrestr_start_ph3;
        logic unrestr_start_ph2;
        logic unrestr_start_ph1;
        logic restr_start_ph3;
        logic restr_start_ph2;
        logic restr_start_ph1;
    } dud_flags_s;

endpackage : dud_pkg

// file: hw/dud_decision.sv
// differential start comparator and decision stage with ahb-lite registers
//
// Local design decisions: the placing of the registers and the AHB-Lite interface to the registers.
module dud_decision
    import dud_pkg::*;
#(
    parameter bit THREE_WINDING = 1'b1
)
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic sample_valid,
    input wire dud_mag_s mags,
    input wire dud_harm_s harm,
    input wire logic user_disable_in,
    output dud_flags_s flags,
    output logic irq
);

    // ==========================================================
    // state
    typedef struct packed {
        logic [LVL_W-1:0] level;
        logic [PCT_W-1:0] base;
        logic [PCT_W-1:0] slope;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_mask;
        logic [2:0] raw_restr;
        logic [2:0] raw_unrestr;
        dud_flags_s flags;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [31:0] rdata;
    } dud_state_s;

    dud_state_s st_ff;
    dud_state_s nxt_st;

    // ==========================================================
    // per-phase comparison, combinational from the sample
    logic [2:0] cmp_unrestr;
    logic [2:0] cmp_restr;
    logic [2:0] harm_blk;

    assign harm_blk[0] = harm.second_harm_restr_ph1 | harm.fifth_harm_restr_ph1;
    assign harm_blk[1] = harm.second_harm_restr_ph2 | harm.fifth_harm_restr_ph2;
    assign harm_blk[2] = harm.second_harm_restr_ph3 | harm.fifth_harm_restr_ph3;

    for (genvar p = 0; p < 3; p++)
    begin : g_phase
        logic [MAG_W-1:0] ter_mag;
        logic [MAG_W+1:0] bias_sum;
        logic [MAG_W:0] bias;
        logic [CMP_W-1:0] diff_scaled;
        logic [CMP_W-1:0] base_term;
        logic [CMP_W-1:0] slope_term;

        // two-winding variant has no tertiary input in the sum
        assign ter_mag = THREE_WINDING ? mags.ter[p] : '0;
        assign bias_sum = {2'b00, mags.prim[p]} + {2'b00, mags.sec[p]} + {2'b00, ter_mag};
        assign bias = bias_sum[MAG_W+1:1];
        assign diff_scaled = CMP_W'(mags.diff[p]) * CMP_W'(PCT_SCALE);
        assign base_term = CMP_W'(st_ff.base) * CMP_W'(PCT_SCALE);
        assign slope_term = CMP_W'(st_ff.slope) * CMP_W'(bias);

        // each phase on its own comparator, no cross coupling
        assign cmp_unrestr[p] = {4'h0, mags.diff[p]} > {8'h00, st_ff.level};
        // flat base section, then the slope above it
        assign cmp_restr[p] = (diff_scaled > base_term) && (diff_scaled > slope_term);
    end

    // ==========================================================
    // ahb-lite slave: zero wait states, always okay
    logic addr_ok;
    logic rd_req;
    logic [7:0] a_off;
    logic [31:0] rd_mux;
    logic [31:0] status_word;
    logic [IRQ_W-1:0] irq_evt;

    assign addr_ok = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
    assign rd_req = addr_ok && !hwrite;
    assign a_off = haddr[7:0];

    always_comb
    begin
        status_word = 32'h0000_0000;
        status_word[STAT_RESTR_LSB +: 3] = st_ff.raw_restr;
        status_word[STAT_UNRESTR_LSB +: 3] = st_ff.raw_unrestr;
        status_word[STAT_RGEN_BIT] = st_ff.flags.restr_start_gen;
        status_word[STAT_UGEN_BIT] = st_ff.flags.unrestr_start_gen;
        status_word[STAT_DIS_BIT] = user_disable_in;
    end

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        if (haddr[31:8] == 24'h00_0000)
        begin
            unique case (a_off)
                OFS_LEVEL: rd_mux = {20'h0_0000, st_ff.level};
                OFS_CHAR: rd_mux = {18'h0_0000, st_ff.slope, 2'h0, st_ff.base};
                OFS_STATUS: rd_mux = status_word;
                OFS_IRQ_STAT: rd_mux = {30'h0000_0000, st_ff.irq_stat};
                OFS_IRQ_MASK: rd_mux = {30'h0000_0000, st_ff.irq_mask};
                default: rd_mux = 32'h0000_0000;
            endcase
        end
    end

    // ==========================================================
    // next state
    always_comb
    begin
        logic [LVL_W-1:0] wr_lvl;
        logic [PCT_W-1:0] wr_base;
        logic [PCT_W-1:0] wr_slope;
        logic [2:0] rs;
        logic [2:0] us;
        logic dis;
        logic [IRQ_W-1:0] clr;
        wr_lvl = hwdata[LVL_W-1:0];
        wr_base = hwdata[CHAR_BASE_LSB +: PCT_W];
        wr_slope = hwdata[CHAR_SLOPE_LSB +: PCT_W];
        rs = st_ff.raw_restr;
        us = st_ff.raw_unrestr;
        dis = user_disable_in;
        clr = '0;
        nxt_st = st_ff;

        // measurement goes on whether or not the function is disabled
        if (sample_valid)
        begin
            rs = cmp_restr & ~harm_blk;
            us = cmp_unrestr;
        end
        nxt_st.raw_restr = rs;
        nxt_st.raw_unrestr = us;

        // exported starts drop at the first clock edge after the disable rises, the same edge that loads the raw results
        nxt_st.flags.restr_start_ph1 = rs[0] & ~dis;
        nxt_st.flags.restr_start_ph2 = rs[1] & ~dis;
        nxt_st.flags.restr_start_ph3 = rs[2] & ~dis;
        nxt_st.flags.unrestr_start_ph1 = us[0] & ~dis;
        nxt_st.flags.unrestr_start_ph2 = us[1] & ~dis;
        nxt_st.flags.unrestr_start_ph3 = us[2] & ~dis;
        nxt_st.flags.restr_start_gen = (|rs) & ~dis;
        nxt_st.flags.unrestr_start_gen = (|us) & ~dis;

        // read data captured at the address phase edge
        if (rd_req)
        begin
            nxt_st.rdata = rd_mux;
            if (haddr[31:8] == 24'h00_0000 && a_off == OFS_IRQ_STAT)
            begin
                clr = st_ff.irq_stat;
            end
        end

        // interrupt events are rising edges of the exported general starts
        irq_evt[IRQ_RGEN_BIT] = nxt_st.flags.restr_start_gen & ~st_ff.flags.restr_start_gen;
        irq_evt[IRQ_UGEN_BIT] = nxt_st.flags.unrestr_start_gen & ~st_ff.flags.unrestr_start_gen;
        // set wins over read-clear
        nxt_st.irq_stat = (st_ff.irq_stat & ~clr) | irq_evt;

        // write data phase
        if (st_ff.wr_pend)
        begin
            unique case (st_ff.wr_addr)
                OFS_LEVEL:
                begin
                    // out-of-range settings are clamped into range
                    if (wr_lvl < LEVEL_MIN)
                    begin
                        nxt_st.level = LEVEL_MIN;
                    end
                    else if (wr_lvl > LEVEL_MAX)
                    begin
                        nxt_st.level = LEVEL_MAX;
                    end
                    else
                    begin
                        nxt_st.level = wr_lvl;
                    end
                end
                OFS_CHAR:
                begin
                    nxt_st.base = (wr_base < PCT_MIN) ? PCT_MIN :
                        ((wr_base > PCT_MAX) ? PCT_MAX : wr_base);
                    nxt_st.slope = (wr_slope < PCT_MIN) ? PCT_MIN :
                        ((wr_slope > PCT_MAX) ? PCT_MAX : wr_slope);
                end
                OFS_IRQ_MASK: nxt_st.irq_mask = hwdata[IRQ_W-1:0];
                default: nxt_st.irq_mask = st_ff.irq_mask;
            endcase
        end

        // unmapped high address bits turn the write into a no-op
        nxt_st.wr_pend = addr_ok && hwrite && (haddr[31:8] == 24'h00_0000);
        nxt_st.wr_addr = a_off;
    end

    // ==========================================================
    // registers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st_ff.level <= LEVEL_RST;
            st_ff.base <= BASE_RST;
            st_ff.slope <= SLOPE_RST;
            st_ff.irq_stat <= '0;
            st_ff.irq_mask <= MASK_RST;
            st_ff.raw_restr <= '0;
            st_ff.raw_unrestr <= '0;
            st_ff.flags <= '0;
            st_ff.wr_pend <= 1'b0;
            st_ff.wr_addr <= 8'h00;
            st_ff.rdata <= 32'h0000_0000;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // ==========================================================
    // outputs
    assign flags = st_ff.flags;
    assign hrdata = st_ff.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign irq = |(st_ff.irq_stat & st_ff.irq_mask);

endmodule : dud_decision

// file: test/dud_decision_assertions.sv
// checker of start flag timing, gating and limits of the decision block
// ==========================================================
// checker
module dud_chk
    import dud_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic sample_valid,
    input wire dud_mag_s mags,
    input wire dud_harm_s harm,
    input wire logic user_disable_in,
    input wire dud_flags_s flags
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    AST_UGEN: assert property (flags.unrestr_start_gen == |flags[5:3])
        else $error("unrestrained general start is not the phase OR");
    AST_RGEN: assert property (flags.restr_start_gen == |flags[2:0])
        else $error("restrained general start is not the phase OR");
    AST_DIS: assert property ($past(user_disable_in) |-> flags == 8'h00)
        else $error("start exported while disabled");
    AST_HOLD: assert property (!sample_valid && !user_disable_in && !$past(user_disable_in)
        |=> $stable(flags))
        else $error("flags moved without a sample");
    AST_H2: assert property (sample_valid && harm.second_harm_restr_ph1
        |=> !flags.restr_start_ph1)
        else $error("second harmonic did not suppress phase one");
    AST_H5: assert property (sample_valid && harm.fifth_harm_restr_ph2
        |=> !flags.restr_start_ph2)
        else $error("fifth harmonic did not suppress phase two");
    AST_UHI: assert property (sample_valid && !user_disable_in && mags.diff[0] > LEVEL_MAX
        |=> flags.unrestr_start_ph1)
        else $error("unrestrained start missing above top level");
    AST_ULO: assert property (sample_valid && mags.diff[1] <= LEVEL_MIN
        |=> !flags.unrestr_start_ph2)
        else $error("unrestrained start below lowest level");
    AST_RLO: assert property (sample_valid && mags.diff[2] <= PCT_MIN
        |=> !flags.restr_start_ph3)
        else $error("restrained start below lowest base");
endmodule : dud_chk

bind dud_decision dud_chk u_dud_chk (.hclk(hclk), .hresetn(hresetn), .sample_valid(sample_valid),
    .mags(mags), .harm(harm), .user_disable_in(user_disable_in), .flags(flags));

// file: test/dud_mag_src.sv
// upstream magnitude source model, one sample per request
// ==========================================================
// model
module dud_mag_src
    import dud_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic go,
    input wire dud_mag_s mag_req,
    output logic sample_valid,
    output dud_mag_s mags
);
    timeunit 1ns;
    timeprecision 1ns;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sample_valid <= 1'b0;
            mags <= '0;
        end
        else
        begin
            sample_valid <= go;
            // not held between samples, so a late read sees garbage
            mags <= go ? mag_req : ~mags;
        end
    end
endmodule : dud_mag_src

// file: test/dud_decision_tb_top.sv
// self-checking bench of the differential decision block
// ==========================================================
// bench
module dud_decision_tb_top
    import dud_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic hclk, hresetn, hsel, hwrite, go, user_disable_in, hreadyout, hresp, sample_valid, irq;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans, mask, exp_stat, prev;
    dud_mag_s mags, mag_req, m;
    dud_harm_s harm;
    dud_flags_s flags, exp_f, raw;
    int failures, checked, seed, lvl, base, slope;

    dud_decision u_dud_decision (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sample_valid(sample_valid),
        .mags(mags), .harm(harm), .user_disable_in(user_disable_in), .flags(flags), .irq(irq));
    dud_mag_src u_dud_mag_src (.hclk(hclk), .hresetn(hresetn), .go(go), .mag_req(mag_req),
        .sample_valid(sample_valid), .mags(mags));

    initial
    begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end

    // ==========================================================
    // tasks
    task check(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task stop_test;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : stop_test

    task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        @(posedge hclk);
        while (hreadyout !== 1'b1 && n < 50)
        begin
            n++;
            @(posedge hclk);
        end
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1 && n < 100)
        begin
            n++;
            @(posedge hclk);
        end
        rd = hrdata;
        check("hresp", 32'h0, {31'h0, hresp});
        // a wait bound used up counts as a mismatch and ends the run
        if (n >= 50)
        begin
            failures++;
            $display("mismatch bus_wait expected %0d seen %0d", 49, n);
            stop_test();
        end
    endtask : bus

    task rdchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check("register", exp, rd);
    endtask : rdchk

    function automatic dud_flags_s calc(input dud_mag_s v, input dud_harm_s h);
        dud_flags_s f;
        int b;
        int d;
        f = '0;
        for (int i = 0; i < 3; i++)
        begin
            b = (int'(v.prim[i]) + int'(v.sec[i]) + int'(v.ter[i])) / 2;
            d = int'(v.diff[i]);
            f[3+i] = d > lvl;
            f[i] = d > base && d * 100 > slope * b && !(h[3+i] | h[i]);
        end
        f[7] = |f[5:3];
        f[6] = |f[2:0];
        return f;
    endfunction : calc

    task sample(input dud_harm_s h);
        mag_req <= m;
        go <= 1'b1;
        @(posedge hclk);
        go <= 1'b0;
        harm <= h;
        @(posedge hclk);
        raw = calc(m, h);
        exp_f = user_disable_in ? 8'h00 : raw;
        @(posedge hclk);
        check("flags", {24'h0, exp_f}, {24'h0, flags});
        exp_stat = exp_stat | (exp_f[7:6] & ~prev);
        prev = exp_f[7:6];
        @(posedge hclk);
        check("irq", {31'h0, |(exp_stat & mask)}, {31'h0, irq});
    endtask : sample

    // ==========================================================
    // main sequence
    initial
    begin
        seed = 16;
        failures = 0;
        checked = 0;
        {hresetn, hsel, hwrite, go, user_disable_in, mask, exp_stat, prev} = '0;
        {haddr, hwdata, htrans} = '0;
        {mag_req, harm, m} = '0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        rdchk(OFS_LEVEL, 32'h320);
        rdchk(OFS_CHAR, 32'h1414);
        rdchk(8'h20, 32'h0);
        bus(1'b1, OFS_LEVEL, 32'd50);
        rdchk(OFS_LEVEL, 32'h050);
        bus(1'b1, OFS_LEVEL, 32'd3000);
        rdchk(OFS_LEVEL, 32'h9C4);
        {lvl, base, slope} = {32'd2500, 32'd20, 32'd20};
        m.diff = {16'd5, 16'd50, 16'd3000};
        sample(6'h0A);
        for (int i = 0; i < 40; i++)
        begin
            lvl = 80 + {$random(seed)} % 2421;
            base = 10 + {$random(seed)} % 41;
            slope = 10 + {$random(seed)} % 41;
            mask = 2'($random(seed));
            bus(1'b1, OFS_LEVEL, 32'(lvl));
            bus(1'b1, OFS_CHAR, 32'(slope * 256 + base));
            bus(1'b1, OFS_IRQ_MASK, {30'h0, mask});
            for (int p = 0; p < 3; p++)
            begin
                m.diff[p] = 16'((i % 4 == 0) ? lvl : lvl - 30 + {$random(seed)} % 61);
                m.prim[p] = 16'({$random(seed)} % 2000);
                m.sec[p] = 16'({$random(seed)} % 2000);
                m.ter[p] = 16'({$random(seed)} % 2000);
            end
            sample(6'($random(seed)));
            if (i % 8 == 7)
            begin
                rdchk(OFS_IRQ_STAT, {30'h0, exp_stat});
                rdchk(OFS_IRQ_MASK, {30'h0, mask});
                exp_stat = 2'h0;
            end
        end
        user_disable_in <= 1'b1;
        m.diff = {16'd3000, 16'd3000, 16'd3000};
        sample(6'h00);
        rdchk(OFS_STATUS, {23'h0, 1'b1, 2'h0, raw[5:0]});
        // disable dropped with reset, so only the reset-cleared raw results keep the starts low, no sample follows
        hresetn <= 1'b0;
        user_disable_in <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        rdchk(OFS_LEVEL, 32'h320);
        rdchk(OFS_STATUS, 32'h0);
        check("flags_reset", 32'h0, {24'h0, flags});
        check("irq_reset", 32'h0, {31'h0, irq});
        stop_test();
    end
endmodule : dud_decision_tb_top
